// ==== verilog/ddp_consts.svh ====
// Constants of the dual data pointer unit: SFR addresses, field positions, reset values.
// Assumes an 8-bit special-function bus with byte addresses.
`ifndef DDP_CONSTS_SVH
`define DDP_CONSTS_SVH
`define DDP_ADDR_PTR_LO 8'h82
`define DDP_ADDR_PTR_HI 8'h83
`define DDP_ADDR_CTRL 8'h85
`define DDP_ADDR_MODE 8'h86
`define DDP_CTRL_RESET 8'h00
`define DDP_MODE_RESET 8'h00
`define DDP_CTRL_SEL_BIT 0
`define DDP_CTRL_TOGGLE_BIT 6
`define DDP_MODE_ZERO_LSB 0
`define DDP_MODE_ONE_LSB 2
`define DDP_PTR_RESET 16'h0000
`endif

// ==== verilog/ddp_pkg.sv ====
// Types of the dual data pointer unit.
// Assumes the constants header is included by users that need numbers.
package ddp_pkg;
  typedef enum logic [1:0] {
    DDP_MODE_HOLD = 2'b00,
    DDP_MODE_RSVD = 2'b01,
    DDP_MODE_INC = 2'b10,
    DDP_MODE_DEC = 2'b11
  } ddp_mode_t;
endpackage : ddp_pkg

// ==== verilog/ddp_pointer.sv ====
// One background pointer register with step logic.
// Assumes the parent decides selection, writes and steps.
`timescale 1ns/10ps
module ddp_pointer #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wdata,
  input wire logic step,
  input wire ddp_pkg::ddp_mode_t mode,
  output logic [WIDTH-1:0] value
);
  import ddp_pkg::*;
  logic [WIDTH-1:0] ptr_ff;
  logic [WIDTH-1:0] nxt_ptr;
  initial begin
    if (WIDTH != 16) begin
      $error("ddp_pointer supports only a 16-bit pointer");
    end
  end
  always_comb begin
    nxt_ptr = ptr_ff;
    if (step) begin
      case (mode)
        DDP_MODE_INC: nxt_ptr = ptr_ff + 16'h0001;
        DDP_MODE_DEC: nxt_ptr = ptr_ff - 16'h0001;
        default: nxt_ptr = ptr_ff;
      endcase
    end
    // A window write beats a step in the same cycle for the byte it writes; the other byte keeps the stepped value.
    if (wr_lo) begin
      nxt_ptr[7:0] = wdata;
    end
    if (wr_hi) begin
      nxt_ptr[15:8] = wdata;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ptr_ff <= 16'h0000;
    end else begin
      ptr_ff <= nxt_ptr;
    end
  end
  assign value = ptr_ff;
endmodule : ddp_pointer

// ==== verilog/ddp_unit.sv ====
// Dual data pointer unit: two background pointers behind one SFR pointer window.
// Assumes the core gives one-cycle SFR strobes and a one-cycle pulse when an
// external data move using the pointer has finished with the old pointer value.
`timescale 1ns/10ps
`include "ddp_consts.svh"
module ddp_unit #(
  parameter int PTR_WIDTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic external_data_move_done,
  output logic [7:0] sfr_rdata_ff,
  output logic sfr_hit_ff,
  output logic [PTR_WIDTH-1:0] architectural_pointer_ff,
  output logic pointer_select_bit_ff,
  output logic auto_toggle_enable_ff
);
  import ddp_pkg::*;
  logic [3:0] pointer_mode_ff;
  logic [PTR_WIDTH-1:0] ptr_zero;
  logic [PTR_WIDTH-1:0] ptr_one;
  logic [PTR_WIDTH-1:0] sel_ptr;
  logic wr_lo;
  logic wr_hi;
  logic wr_ctrl;
  logic wr_mode;
  logic hit;
  logic [7:0] nxt_rdata;
  logic [PTR_WIDTH-1:0] nxt_arch;
  logic nxt_sel;
  ddp_mode_t mode_zero;
  ddp_mode_t mode_one;

  initial begin
    if (PTR_WIDTH != 16) begin
      $error("ddp_unit supports only a 16-bit pointer");
    end
  end

  assign wr_lo = sfr_wr && (sfr_addr == `DDP_ADDR_PTR_LO);
  assign wr_hi = sfr_wr && (sfr_addr == `DDP_ADDR_PTR_HI);
  assign wr_ctrl = sfr_wr && (sfr_addr == `DDP_ADDR_CTRL);
  assign wr_mode = sfr_wr && (sfr_addr == `DDP_ADDR_MODE);
  assign hit = (sfr_addr == `DDP_ADDR_PTR_LO) || (sfr_addr == `DDP_ADDR_PTR_HI)
    || (sfr_addr == `DDP_ADDR_CTRL) || (sfr_addr == `DDP_ADDR_MODE);
  assign mode_zero = ddp_mode_t'(pointer_mode_ff[`DDP_MODE_ZERO_LSB +: 2]);
  assign mode_one = ddp_mode_t'(pointer_mode_ff[`DDP_MODE_ONE_LSB +: 2]);
  assign sel_ptr = pointer_select_bit_ff ? ptr_one : ptr_zero;

  // Write strobes reach only the selected pointer, so the other stays hidden.
  ddp_pointer #(.WIDTH(PTR_WIDTH)) u_ptr_zero (
    .clock(clock),
    .nrst(nrst),
    .wr_lo(wr_lo && !pointer_select_bit_ff),
    .wr_hi(wr_hi && !pointer_select_bit_ff),
    .wdata(sfr_wdata),
    .step(external_data_move_done && !pointer_select_bit_ff),
    .mode(mode_zero),
    .value(ptr_zero)
  );
  ddp_pointer #(.WIDTH(PTR_WIDTH)) u_ptr_one (
    .clock(clock),
    .nrst(nrst),
    .wr_lo(wr_lo && pointer_select_bit_ff),
    .wr_hi(wr_hi && pointer_select_bit_ff),
    .wdata(sfr_wdata),
    .step(external_data_move_done && pointer_select_bit_ff),
    .mode(mode_one),
    .value(ptr_one)
  );

  // A control write in the same cycle as a toggle wins, since software intent is explicit.
  always_comb begin
    nxt_sel = pointer_select_bit_ff;
    if (external_data_move_done && auto_toggle_enable_ff) begin
      nxt_sel = !pointer_select_bit_ff;
    end
    if (wr_ctrl) begin
      nxt_sel = sfr_wdata[`DDP_CTRL_SEL_BIT];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pointer_select_bit_ff <= 1'((`DDP_CTRL_RESET >> `DDP_CTRL_SEL_BIT) & 8'h01);
      auto_toggle_enable_ff <= 1'((`DDP_CTRL_RESET >> `DDP_CTRL_TOGGLE_BIT) & 8'h01);
    end else begin
      pointer_select_bit_ff <= nxt_sel;
      if (wr_ctrl) begin
        auto_toggle_enable_ff <= sfr_wdata[`DDP_CTRL_TOGGLE_BIT];
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pointer_mode_ff <= 4'(`DDP_MODE_RESET);
    end else if (wr_mode) begin
      pointer_mode_ff <= sfr_wdata[3:0];
    end
  end

  // Reserved bits read as zero.
  always_comb begin
    nxt_rdata = 8'h00;
    case (sfr_addr)
      `DDP_ADDR_PTR_LO: nxt_rdata = sel_ptr[7:0];
      `DDP_ADDR_PTR_HI: nxt_rdata = sel_ptr[15:8];
      `DDP_ADDR_CTRL: begin
        nxt_rdata[`DDP_CTRL_SEL_BIT] = pointer_select_bit_ff;
        nxt_rdata[`DDP_CTRL_TOGGLE_BIT] = auto_toggle_enable_ff;
      end
      `DDP_ADDR_MODE: nxt_rdata = {4'h0, pointer_mode_ff};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata_ff <= 8'h00;
      sfr_hit_ff <= 1'b0;
    end else begin
      sfr_rdata_ff <= sfr_rd ? nxt_rdata : 8'h00;
      sfr_hit_ff <= sfr_rd && hit;
    end
  end

  // The address output lags the pointer by one cycle so it comes from a flop.
  assign nxt_arch = sel_ptr;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      architectural_pointer_ff <= `DDP_PTR_RESET;
    end else begin
      architectural_pointer_ff <= nxt_arch;
    end
  end

  property p_toggle;
    @(posedge clock) disable iff (!nrst)
    (external_data_move_done && auto_toggle_enable_ff && !wr_ctrl)
      |=> (pointer_select_bit_ff != $past(pointer_select_bit_ff));
  endproperty
  a_toggle: assert property (p_toggle) else $error("selection did not toggle");

  property p_no_toggle;
    @(posedge clock) disable iff (!nrst)
    (!auto_toggle_enable_ff && !wr_ctrl) |=> $stable(pointer_select_bit_ff);
  endproperty
  a_no_toggle: assert property (p_no_toggle) else $error("selection moved by itself");

  property p_inc;
    @(posedge clock) disable iff (!nrst)
    (external_data_move_done && !pointer_select_bit_ff && mode_zero == DDP_MODE_INC
      && !wr_lo && !wr_hi) |=> (ptr_zero == 16'($past(ptr_zero) + 16'h0001));
  endproperty
  a_inc: assert property (p_inc) else $error("pointer zero did not increment");

  property p_dec;
    @(posedge clock) disable iff (!nrst)
    (external_data_move_done && pointer_select_bit_ff && mode_one == DDP_MODE_DEC
      && !wr_lo && !wr_hi) |=> (ptr_one == 16'($past(ptr_one) - 16'h0001));
  endproperty
  a_dec: assert property (p_dec) else $error("pointer one did not decrement");

  property p_hidden;
    @(posedge clock) disable iff (!nrst)
    pointer_select_bit_ff |=> $stable(ptr_zero);
  endproperty
  a_hidden: assert property (p_hidden) else $error("hidden pointer changed");

  property p_hold;
    @(posedge clock) disable iff (!nrst)
    (!external_data_move_done && !wr_lo && !wr_hi) |=> ($stable(ptr_zero) && $stable(ptr_one));
  endproperty
  a_hold: assert property (p_hold) else $error("pointer changed without cause");

  property p_write_wins;
    @(posedge clock) disable iff (!nrst)
    (wr_lo && !pointer_select_bit_ff) |=> (ptr_zero[7:0] == $past(sfr_wdata));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("window write lost");

  sequence s_read_lo;
    sfr_rd && sfr_addr == `DDP_ADDR_PTR_LO;
  endsequence
  property p_read_lo;
    @(posedge clock) disable iff (!nrst)
    s_read_lo |=> (sfr_rdata_ff == $past(sel_ptr[7:0]));
  endproperty
  a_read_lo: assert property (p_read_lo) else $error("window read wrong");

  property p_mode_rsvd;
    @(posedge clock) disable iff (!nrst)
    (sfr_rd && sfr_addr == `DDP_ADDR_MODE) |=> (sfr_rdata_ff[7:4] == 4'h0);
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved mode bits set");

  // A move with no window write in the same cycle, split by the pointer it steps.
  sequence s_move_zero;
    external_data_move_done && !pointer_select_bit_ff && !wr_lo && !wr_hi;
  endsequence

  sequence s_move_one;
    external_data_move_done && pointer_select_bit_ff && !wr_lo && !wr_hi;
  endsequence

  property p_inc_one;
    @(posedge clock) disable iff (!nrst)
    (s_move_one and (mode_one == DDP_MODE_INC)) |=> (ptr_one == 16'($past(ptr_one) + 16'h0001));
  endproperty
  a_inc_one: assert property (p_inc_one) else $error("pointer one did not increment");

  property p_dec_zero;
    @(posedge clock) disable iff (!nrst)
    (s_move_zero and (mode_zero == DDP_MODE_DEC)) |=> (ptr_zero == 16'($past(ptr_zero) - 16'h0001));
  endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("pointer zero did not decrement");

  // The reserved code must hold, so a stray mode write never moves a pointer.
  property p_rsvd_zero;
    @(posedge clock) disable iff (!nrst)
    (s_move_zero and (mode_zero == DDP_MODE_RSVD)) |=> $stable(ptr_zero);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved mode moved pointer");

  property p_hold_zero;
    @(posedge clock) disable iff (!nrst)
    (s_move_zero and (mode_zero == DDP_MODE_HOLD)) |=> $stable(ptr_zero);
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("hold mode moved pointer");

  property p_hidden_one;
    @(posedge clock) disable iff (!nrst)
    !pointer_select_bit_ff |=> $stable(ptr_one);
  endproperty
  a_hidden_one: assert property (p_hidden_one) else $error("hidden pointer changed");

  property p_ctrl_wins;
    @(posedge clock) disable iff (!nrst)
    wr_ctrl |=> (pointer_select_bit_ff == $past(sfr_wdata[`DDP_CTRL_SEL_BIT]));
  endproperty
  a_ctrl_wins: assert property (p_ctrl_wins) else $error("select write lost");

  property p_toggle_write;
    @(posedge clock) disable iff (!nrst)
    wr_ctrl |=> (auto_toggle_enable_ff == $past(sfr_wdata[`DDP_CTRL_TOGGLE_BIT]));
  endproperty
  a_toggle_write: assert property (p_toggle_write) else $error("toggle write lost");

  property p_mode_write;
    @(posedge clock) disable iff (!nrst)
    wr_mode |=> (pointer_mode_ff == $past(sfr_wdata[3:0]));
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("mode write lost");

  property p_read_hi;
    @(posedge clock) disable iff (!nrst)
    (sfr_rd && sfr_addr == `DDP_ADDR_PTR_HI) |=> (sfr_rdata_ff == $past(sel_ptr[15:8]));
  endproperty
  a_read_hi: assert property (p_read_hi) else $error("window high read wrong");

  property p_ctrl_read;
    @(posedge clock) disable iff (!nrst)
    (sfr_rd && sfr_addr == `DDP_ADDR_CTRL) |=> (sfr_rdata_ff
      == {1'b0, $past(auto_toggle_enable_ff), 5'h00, $past(pointer_select_bit_ff)});
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_hit;
    @(posedge clock) disable iff (!nrst)
    (sfr_rd && hit) |=> sfr_hit_ff;
  endproperty
  a_hit: assert property (p_hit) else $error("register read not flagged");

  // Idle read data stays zero so a careless core cannot latch stale bytes.
  property p_idle_read;
    @(posedge clock) disable iff (!nrst)
    !sfr_rd |=> ((sfr_rdata_ff == 8'h00) && !sfr_hit_ff);
  endproperty
  a_idle_read: assert property (p_idle_read) else $error("read data without read");

  property p_arch_follow;
    @(posedge clock) disable iff (!nrst)
    1'b1 |=> (architectural_pointer_ff == $past(sel_ptr));
  endproperty
  a_arch_follow: assert property (p_arch_follow) else $error("address output stale");

  property p_write_hi;
    @(posedge clock) disable iff (!nrst)
    (wr_hi && pointer_select_bit_ff) |=> (ptr_one[15:8] == $past(sfr_wdata));
  endproperty
  a_write_hi: assert property (p_write_hi) else $error("window high write lost");
endmodule : ddp_unit

// ==== tb/ddp_core_model.sv ====
// Core-side model: drives the SFR strobes and the move pulse of the pointer unit.
// Assumes a free-running clock; all changes land just after a rising edge.
`timescale 1ns/10ps
module ddp_core_model (
  input wire logic clock,
  input wire logic [7:0] sfr_rdata_ff,
  input wire logic sfr_hit_ff,
  output logic [7:0] sfr_addr,
  output logic sfr_wr,
  output logic sfr_rd,
  output logic [7:0] sfr_wdata,
  output logic external_data_move_done
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    external_data_move_done = 1'b0;
  end
  // A move pulse may ride with a write; code byte moves never pulse.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic mv);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    external_data_move_done <= mv;
    @(posedge clock);
    sfr_wr <= 1'b0;
    external_data_move_done <= 1'b0;
    sfr_wdata <= ~d;
    sfr_addr <= ~a;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic h);
    @(posedge clock);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge clock);
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    #1;
    q = sfr_rdata_ff;
    h = sfr_hit_ff;
  endtask : rd
endmodule : ddp_core_model

// ==== tb/ddp_unit_tb_top.sv ====
// Testbench of the dual data pointer unit, driven through the core model.
// Assumes the core model sits on the SFR side; results are judged here.
`timescale 1ns/10ps
module ddp_unit_tb_top;
  import ddp_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr, wdata, rdata, q;
  logic wr, rd, mvd, hit, sel, tog, h;
  logic [15:0] ap;
  int miscompares = 0;
  int compares = 0;
  logic [15:0] exp_m [4] = '{16'hffff, 16'hffff, 16'h0000, 16'hfffe};
  always #2.5 clock = ~clock;
  ddp_core_model u_core (.clock(clock), .sfr_rdata_ff(rdata), .sfr_hit_ff(hit),
    .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata),
    .external_data_move_done(mvd));
  ddp_unit DUT (.clock(clock), .nrst(nrst), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_wdata(wdata), .external_data_move_done(mvd),
    .sfr_rdata_ff(rdata), .sfr_hit_ff(hit), .architectural_pointer_ff(ap),
    .pointer_select_bit_ff(sel), .auto_toggle_enable_ff(tog));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [8:0] e);
    u_core.rd(a, q, h);
    chk({7'h00, h, q}, {7'h00, e});
  endtask : rchk
  task automatic setp(input logic [15:0] v);
    u_core.wr(8'h82, v[7:0], 1'b0);
    u_core.wr(8'h83, v[15:8], 1'b0);
  endtask : setp
  task automatic rptr(input logic [15:0] e);
    logic [7:0] lo;
    u_core.rd(8'h82, lo, h);
    u_core.rd(8'h83, q, h);
    chk({q, lo}, e);
  endtask : rptr
  task automatic t_reset;
    chk(ap, 16'h0000);
    chk({14'h0000, sel, tog}, 16'h0000);
    rchk(8'h85, 9'h100);
    rchk(8'h86, 9'h100);
    rchk(8'h84, 9'h000);
  endtask : t_reset
  task automatic t_select;
    setp(16'h1234);
    u_core.wr(8'h85, 8'hff, 1'b0);
    rchk(8'h85, 9'h141);
    setp(16'habcd);
    rptr(16'habcd);
    u_core.wr(8'h85, 8'h00, 1'b0);
    rptr(16'h1234);
    chk(ap, 16'h1234);
  endtask : t_select
  // Wrap and reserved-code cases share one table so every mode is set.
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      setp(16'hffff);
      u_core.wr(8'h86, {4'h0, 2'(i), 2'(i)}, 1'b0);
      rchk(8'h86, {5'h10, 2'(i), 2'(i)});
      u_core.wr(8'h00, 8'h00, 1'b1);
      rptr(exp_m[i]);
    end
    u_core.wr(8'h85, 8'h01, 1'b0);
    rptr(16'habcd);
    u_core.wr(8'h00, 8'h00, 1'b1);
    rptr(16'habcc);
  endtask : t_modes
  task automatic t_toggle;
    setp(16'h0020);
    u_core.wr(8'h85, 8'h40, 1'b0);
    setp(16'h0010);
    u_core.wr(8'h86, 8'h0a, 1'b0);
    u_core.wr(8'h00, 8'h00, 1'b1);
    #1;
    chk({15'h0000, sel}, 16'h0001);
    rptr(16'h0020);
    u_core.wr(8'h00, 8'h00, 1'b1);
    #1;
    chk({15'h0000, sel}, 16'h0000);
    rptr(16'h0011);
    u_core.wr(8'h85, 8'h01, 1'b0);
    rptr(16'h0021);
    u_core.wr(8'h82, 8'h77, 1'b1);
    rptr(16'h0077);
  endtask : t_toggle
  task automatic final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  initial begin
    #20000;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    #1;
    t_reset();
    t_select();
    t_modes();
    t_toggle();
    final_report();
  end
endmodule : ddp_unit_tb_top
